/* sta_pkg.sv */
// Shared constants for the self test and probe routing block.
package sta_pkg;
	// Register byte offsets on the Wishbone bus.
	localparam logic [7:0] OFS_SELF_TEST  = 8'h00;
	localparam logic [7:0] OFS_TEST_SEL1  = 8'h04;
	localparam logic [7:0] OFS_TEST_SEL2  = 8'h08;
	localparam logic [7:0] OFS_PROBE_ROUT = 8'h0C;
	localparam logic [7:0] OFS_DAC_ONE    = 8'h10;
	localparam logic [7:0] OFS_DAC_TWO    = 8'h14;
	localparam logic [7:0] OFS_COMMAND    = 8'h18;
	localparam logic [7:0] OFS_STATUS     = 8'h1C;

	// Reset values.
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [5:0] RST_DAC  = 6'h00;

	// Field positions.
	localparam int SUBADDR_MSB = 4;
	localparam int PRBS_LSB    = 5;
	localparam int PRBS_MSB    = 6;
	localparam int BITSEL_MSB  = 2;
	localparam int DAC_MSB     = 5;
	localparam int CMD_MSB     = 3;

	// Self test enable value and last signature index.
	localparam logic [7:0] SELF_TEST_ON  = 8'h09;
	localparam logic [6:0] SIG_LAST      = 7'h3F;

	// Command codes written to the command register.
	localparam logic [3:0] CMD_IDLE      = 4'h0;
	localparam logic [3:0] CMD_CHECKSUM  = 4'h3;
	localparam logic [3:0] CMD_TRANSMIT  = 4'h4;
	localparam logic [3:0] CMD_SOFT_RST  = 4'hF;

	// Probe bus subaddresses.
	localparam logic [4:0] BUS_RECEIVER  = 5'h07;
	localparam logic [4:0] BUS_OSC       = 5'h0D;

	// Pseudo-random pattern selections.
	localparam logic [1:0] PRBS_OFF = 2'h0;
	localparam logic [1:0] PRBS_9   = 2'h1;
	localparam logic [1:0] PRBS_15  = 2'h2;

	// Probe pin source codes.
	localparam logic [3:0] SRC_TRISTATE  = 4'h0;
	localparam logic [3:0] SRC_DAC_REG   = 4'h1;
	localparam logic [3:0] SRC_CORR      = 4'h2;
	localparam logic [3:0] SRC_THRESH    = 4'h4;
	localparam logic [3:0] SRC_ADC_I     = 4'h5;
	localparam logic [3:0] SRC_ADC_Q     = 4'h6;
	localparam logic [3:0] SRC_HIGH      = 4'hA;
	localparam logic [3:0] SRC_LOW       = 4'hB;
	localparam logic [3:0] SRC_TX_BUSY   = 4'hC;
	localparam logic [3:0] SRC_RX_BUSY   = 4'hD;
	localparam logic [3:0] SRC_SUBCARR   = 4'hE;
	localparam logic [3:0] SRC_BUS_BIT   = 4'hF;

	// Self test sequencer states.
	typedef enum logic [0:0] {
		ST_IDLE = 1'b0,
		ST_RUN  = 1'b1
	} sta_st_e;
endpackage

/* sta_sig_rom.sv */
// Signature table for the self test, one byte per entry, registered read.
`timescale 1ns/1ps
`default_nettype none
module sta_sig_rom #(
	parameter bit SILICON_V2 = 1'b1        // Selects the second silicon signature.
) (
	input  wire logic       clk,           // System clock.
	input  wire logic       rst_b,         // Asynchronous reset, active low.
	input  wire logic [5:0] addr,          // Byte index into the signature.
	output logic      [7:0] q              // Registered table byte.
);
	typedef struct packed {
		logic [7:0] q;
	} sta_rom_s;

	localparam logic [511:0] SIG_A = {
		128'h00C637D532B7575CC2D87C4DD970C773,
		128'h10E6D2AA5EA13E5A14AF3061C970DB2E,
		128'h642272B5BD65F4EC22BCD37235CDAA41,
		128'h1FA7F35314DE7E02D90FB55E251D2979};
	localparam logic [511:0] SIG_B = {
		128'h00EB66BA57BF2395D0E30D3D27895CDE,
		128'h9D3BA700215B8982513AEB020CA50049,
		128'h7C844DB3CCD21B815D4876D5716121A9,
		128'h86968338CF9D5B6DDC15BA3E7D953B2F};

	sta_rom_s st_reg;
	sta_rom_s st_next;

	// Table lookup; the version is fixed at build time, so only one table is kept.
	always_comb begin
		st_next.q = SILICON_V2 ? SIG_B[8 * (6'h3F - addr) +: 8] : SIG_A[8 * (6'h3F - addr) +: 8];
	end

	// Read data register.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign q = st_reg.q;
endmodule
`default_nettype wire

/* sta_prbs.sv */
// Pseudo-random bit source for test transmissions.
`timescale 1ns/1ps
`default_nettype none
module sta_prbs (
	input  wire logic       clk,           // System clock.
	input  wire logic       rst_b,         // Asynchronous reset, active low.
	input  wire logic       start,         // One-cycle start pulse.
	input  wire logic       stop,          // One-cycle stop pulse.
	input  wire logic [1:0] mode,          // Pattern choice at start.
	input  wire logic       bit_en,        // One-cycle enable per transmitted bit.
	output logic            bit_q,         // Current pattern bit.
	output logic            valid_q,       // Pulse with each new bit.
	output logic            run_q,         // Pattern transmission active.
	output logic      [1:0] mode_q         // Latched pattern choice for the framer.
);
	typedef struct packed {
		logic [14:0] lfsr;
		logic        run;
		logic [1:0]  mode;
		logic        bit_v;
		logic        valid;
	} sta_prbs_s;

	sta_prbs_s st_reg;
	sta_prbs_s st_next;
	logic      fb;

	// Shift on each bit enable; taps at 9/5 or 15/14, seeded with ones.
	always_comb begin
		st_next = st_reg;
		st_next.valid = 1'b0;
		fb = (st_reg.mode == sta_pkg::PRBS_9) ? (st_reg.lfsr[8] ^ st_reg.lfsr[4])
		                                      : (st_reg.lfsr[14] ^ st_reg.lfsr[13]);
		if (stop) begin
			st_next.run = 1'b0;
		end else if (start && mode != sta_pkg::PRBS_OFF) begin
			st_next.run = 1'b1;
			st_next.mode = mode;
			st_next.lfsr = '1;
		end else if (st_reg.run && bit_en) begin
			st_next.lfsr = {st_reg.lfsr[13:0], fb};
			st_next.bit_v = fb;
			st_next.valid = 1'b1;
		end
	end

	// State register.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign bit_q   = st_reg.bit_v;
	assign valid_q = st_reg.valid;
	assign run_q   = st_reg.run;
	assign mode_q  = st_reg.mode;
endmodule
`default_nettype wire

/* sta_top.sv */
// Self test sequencer, probe bus and probe pin routing with Wishbone registers.
//
// Local design decisions: register access over Wishbone and the address map.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// RL1 - Host soft-resets and clears the buffer first.
// RL2 - Host writes 09h to enable self test.
// RL3 - Checksum command in self test mode starts the test.
// RL4 - Self test pushes exactly 64 signature bytes.
// RL5 - Five-bit subaddress picks the bus group.
// RL6 - Subaddress 07h drives receiver signals.
// RL7 - Subaddress 0Dh drives oscillator signals.
// RL8 - Each pin has a four-bit source; 0000 floats it.
// RL9 - Codes 1 to 6 route DAC sources; code 3 floats the pin.
// RL10 - Codes A to F route digital levels.
// RL11 - Upper nibble feeds pin one, lower pin two.
// RL12 - At 106 kBd rx busy excludes start bits.
// RL13 - At 106 kBd tx busy includes start and parity.
// RL14 - At higher rates busy covers data and CRC only.
// RL15 - Test select one picks the bus bit line.
// RL16 - PRBS9 or PRBS15 starts on the transmit command.
// RL17 - Host sets transmission registers before a pattern.
// RL18 - Test DAC codes 00h to 3Fh drive the probe.
// RL19 - Selector writes reach the pins without a command.
module sta_top #(
	parameter bit SILICON_V2 = 1'b1        // Signature table choice.
) (
	input  wire logic        clk,            // System clock, 25 MHz.
	input  wire logic        rst_b,          // Asynchronous reset, active low.
	input  wire logic        wb_cyc_i,       // Wishbone cycle.
	input  wire logic        wb_stb_i,       // Wishbone strobe.
	input  wire logic        wb_we_i,        // Wishbone write enable.
	input  wire logic [7:0]  wb_adr_i,       // Wishbone byte address.
	input  wire logic [3:0]  wb_sel_i,       // Wishbone byte lanes.
	input  wire logic [31:0] wb_dat_i,       // Wishbone write data.
	output logic      [31:0] wb_dat_o,       // Wishbone read data.
	output logic             wb_ack_o,       // Wishbone acknowledge.
	input  wire logic        rx_data_bit,    // Received bit stream.
	input  wire logic        rx_coll,        // Bit collision seen.
	input  wire logic        rx_valid,       // Data and collision valid.
	input  wire logic        rx_stop,        // Stop condition seen.
	input  wire logic        receiver_clear, // Receiver held in reset.
	input  wire logic        osc_stable,     // Oscillator stable output.
	input  wire logic        osc_raw_clock,  // Raw oscillator.
	input  wire logic        rate_106,       // Link runs at 106 kBd.
	input  wire logic        tx_start_ph,    // Tx start bit.
	input  wire logic        tx_data_ph,     // Tx data or CRC.
	input  wire logic        tx_parity_ph,   // Tx parity.
	input  wire logic        rx_start_ph,    // Rx start bit.
	input  wire logic        rx_data_ph,     // Rx data or CRC.
	input  wire logic        rx_parity_ph,   // Rx parity.
	input  wire logic        subcarrier_det, // Subcarrier detected.
	input  wire logic [5:0]  correlator_out, // Correlator level.
	input  wire logic [5:0]  threshold_level,// Minimum level.
	input  wire logic [5:0]  adc_i,          // In-phase ADC sample.
	input  wire logic [5:0]  adc_q,          // Quadrature ADC sample.
	input  wire logic        tx_bit_en,      // One pulse per transmitted bit.
	output logic             fifo_wr_en,     // Push into the data FIFO.
	output logic      [7:0]  fifo_wr_data,   // Byte pushed into the FIFO.
	output logic             prbs_bit,       // Pseudo-random bit to the framer.
	output logic             prbs_valid,     // Pulse with each pattern bit.
	output logic             prbs_active,    // Framer adds framing bits.
	output logic      [1:0]  prbs_mode,      // Pattern in use.
	output logic      [5:0]  probe_bus_d,    // Probe bus, bit 0 is D1.
	output logic      [5:0]  probe_bus_oe,   // Drive enable per bus pin.
	output logic             probe_pin_one,  // Level, pin one.
	output logic             probe_one_oe,   // Drive enable, pin one.
	output logic      [5:0]  probe_one_dac,  // DAC code for pin one.
	output logic             probe_one_den,  // DAC enable, pin one.
	output logic             probe_pin_two,  // Level, pin two.
	output logic             probe_two_oe,   // Drive enable, pin two.
	output logic      [5:0]  probe_two_dac,  // DAC code for pin two.
	output logic             probe_two_den   // DAC enable, pin two.
);
	typedef struct packed {
		logic [7:0]     self_test_control;
		logic [2:0]     probe_bit_line_select;
		logic [7:0]     test_select_two;
		logic [7:0]     probe_route;
		logic [5:0]     test_dac_one;
		logic [5:0]     test_dac_two;
		logic           ack;
		logic [31:0]    rdat;
		sta_pkg::sta_st_e st;
		logic [6:0]     idx;
		logic           v1;
		logic           done;
		logic           fifo_we;
		logic [7:0]     fifo_wd;
		logic           osc_prev;
		logic [1:0]     osc_cnt;
		logic           osc_div_eight;
		logic [5:0]     bus_d;
		logic [5:0]     bus_oe;
		logic           tx_busy_flag;
		logic           rx_busy_flag;
		logic [1:0]     p_out;
		logic [1:0]     p_oe;
		logic [11:0]    p_dac;
		logic [1:0]     p_den;
	} sta_state_s;

	sta_state_s st_reg;
	sta_state_s st_next;

	logic       bus_req;
	logic       wr_go;
	logic       cmd_wr;
	logic [3:0] cmd;
	logic       prbs_start;
	logic       prbs_stop;
	logic       rom_issue;
	logic [7:0] rom_q;
	logic       probe_bus_bit;
	logic [1:0] src_out;
	logic [1:0] src_oe;
	logic [1:0] src_den;
	logic [11:0] src_dac;

	// A request is answered one cycle after it is seen; ack drops the cycle after.
	assign bus_req = wb_cyc_i && wb_stb_i && !st_reg.ack;
	assign wr_go   = bus_req && wb_we_i && wb_sel_i[0];
	assign cmd_wr  = wr_go && (wb_adr_i == sta_pkg::OFS_COMMAND);
	assign cmd     = wb_dat_i[sta_pkg::CMD_MSB:0];
	assign prbs_start = cmd_wr && (cmd == sta_pkg::CMD_TRANSMIT); // [RL16]
	assign prbs_stop  = cmd_wr && (cmd == sta_pkg::CMD_IDLE || cmd == sta_pkg::CMD_SOFT_RST);
	assign rom_issue  = (st_reg.st == sta_pkg::ST_RUN);

	// Selected bus line feeds the probe bus bit; values 1 to 6 pick D1 to D6.
	always_comb begin
		probe_bus_bit = 1'b0;
		if (st_reg.probe_bit_line_select != 3'h0 && st_reg.probe_bit_line_select != 3'h7) begin
			probe_bus_bit = st_reg.bus_d[st_reg.probe_bit_line_select - 3'h1]; // [RL15]
		end
	end

	// Per-pin source decode; the pins differ only in nibble and DAC register.
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_probe
			logic [3:0] sel;
			logic [5:0] own_dac;
			assign sel     = (gi == 0) ? st_reg.probe_route[7:4] : st_reg.probe_route[3:0]; // [RL11]
			assign own_dac = (gi == 0) ? st_reg.test_dac_one : st_reg.test_dac_two;
			always_comb begin
				src_out[gi] = 1'b0;
				src_oe[gi]  = 1'b0;
				src_den[gi] = 1'b0;
				src_dac[gi*6 +: 6] = 6'h00;
				// Reserved codes float the pin, the safest choice on a shared net.
				unique case (sel)
					sta_pkg::SRC_TRISTATE: src_oe[gi] = 1'b0; // [RL8]
					sta_pkg::SRC_DAC_REG: begin
						src_den[gi] = 1'b1;
						src_dac[gi*6 +: 6] = own_dac; // [RL18]
					end
					sta_pkg::SRC_CORR: begin
						src_den[gi] = 1'b1;
						src_dac[gi*6 +: 6] = correlator_out; // [RL9]
					end
					sta_pkg::SRC_THRESH: begin
						src_den[gi] = 1'b1;
						src_dac[gi*6 +: 6] = threshold_level; // [RL9]
					end
					sta_pkg::SRC_ADC_I: begin
						src_den[gi] = 1'b1;
						src_dac[gi*6 +: 6] = adc_i; // [RL9]
					end
					sta_pkg::SRC_ADC_Q: begin
						src_den[gi] = 1'b1;
						src_dac[gi*6 +: 6] = adc_q; // [RL9]
					end
					sta_pkg::SRC_HIGH: begin
						src_oe[gi]  = 1'b1;
						src_out[gi] = 1'b1; // [RL10]
					end
					sta_pkg::SRC_LOW: src_oe[gi] = 1'b1; // [RL10]
					sta_pkg::SRC_TX_BUSY: begin
						src_oe[gi]  = 1'b1;
						src_out[gi] = st_reg.tx_busy_flag; // [RL10]
					end
					sta_pkg::SRC_RX_BUSY: begin
						src_oe[gi]  = 1'b1;
						src_out[gi] = st_reg.rx_busy_flag; // [RL10]
					end
					sta_pkg::SRC_SUBCARR: begin
						src_oe[gi]  = 1'b1;
						src_out[gi] = subcarrier_det; // [RL10]
					end
					sta_pkg::SRC_BUS_BIT: begin
						src_oe[gi]  = 1'b1;
						src_out[gi] = probe_bus_bit; // [RL10]
					end
					default: src_oe[gi] = 1'b0;
				endcase
			end
		end
	endgenerate

	// Next state of the whole block.
	always_comb begin
		st_next = st_reg;
		st_next.ack = bus_req;
		st_next.fifo_we = 1'b0;

		// Register writes and reads; unmapped offsets ack with zero and store nothing.
		if (wr_go) begin
			unique case (wb_adr_i)
				sta_pkg::OFS_SELF_TEST:  st_next.self_test_control = wb_dat_i[7:0]; // [RL2]
				sta_pkg::OFS_TEST_SEL1:  st_next.probe_bit_line_select = wb_dat_i[sta_pkg::BITSEL_MSB:0];
				sta_pkg::OFS_TEST_SEL2:  st_next.test_select_two = wb_dat_i[7:0]; // [RL19]
				sta_pkg::OFS_PROBE_ROUT: st_next.probe_route = wb_dat_i[7:0]; // [RL19]
				sta_pkg::OFS_DAC_ONE:    st_next.test_dac_one = wb_dat_i[sta_pkg::DAC_MSB:0]; // [RL18]
				sta_pkg::OFS_DAC_TWO:    st_next.test_dac_two = wb_dat_i[sta_pkg::DAC_MSB:0]; // [RL18]
				default: st_next.ack = bus_req;
			endcase
		end
		st_next.rdat = 32'h0000_0000;
		if (bus_req && !wb_we_i) begin
			unique case (wb_adr_i)
				sta_pkg::OFS_SELF_TEST:  st_next.rdat[7:0] = st_reg.self_test_control;
				sta_pkg::OFS_TEST_SEL1:  st_next.rdat[2:0] = st_reg.probe_bit_line_select;
				sta_pkg::OFS_TEST_SEL2:  st_next.rdat[7:0] = st_reg.test_select_two;
				sta_pkg::OFS_PROBE_ROUT: st_next.rdat[7:0] = st_reg.probe_route;
				sta_pkg::OFS_DAC_ONE:    st_next.rdat[5:0] = st_reg.test_dac_one;
				sta_pkg::OFS_DAC_TWO:    st_next.rdat[5:0] = st_reg.test_dac_two;
				sta_pkg::OFS_STATUS:     st_next.rdat[9:0] = {st_reg.done, rom_issue, prbs_active, st_reg.idx};
				default: st_next.rdat = 32'h0000_0000;
			endcase
		end

		// Self test: issue 64 table reads, push each byte two cycles later.
		st_next.v1 = rom_issue;
		if (st_reg.v1) begin
			st_next.fifo_we = 1'b1; // [RL4]
			st_next.fifo_wd = rom_q;
		end
		unique case (st_reg.st)
			sta_pkg::ST_IDLE: begin
				if (cmd_wr && cmd == sta_pkg::CMD_CHECKSUM
				    && st_reg.self_test_control == sta_pkg::SELF_TEST_ON) begin
					st_next.st = sta_pkg::ST_RUN; // [RL3]
					st_next.idx = 7'h00;
					st_next.done = 1'b0;
				end
			end
			sta_pkg::ST_RUN: begin
				if (st_reg.idx == sta_pkg::SIG_LAST) begin
					st_next.st = sta_pkg::ST_IDLE; // [RL4]
				end else begin
					st_next.idx = st_reg.idx + 7'h01;
				end
			end
		endcase
		// Done rises with the final push so status never reports early.
		if (st_reg.v1 && !rom_issue) begin
			st_next.done = 1'b1;
		end

		// Divide the sampled oscillator by eight: toggle every fourth rising edge.
		st_next.osc_prev = osc_raw_clock;
		if (osc_raw_clock && !st_reg.osc_prev) begin
			st_next.osc_cnt = st_reg.osc_cnt + 2'h1;
			if (st_reg.osc_cnt == 2'h3) begin
				st_next.osc_div_eight = !st_reg.osc_div_eight; // [RL7]
			end
		end

		// Busy flags: parity and tx start bits only count at 106 kBd; rx start bits never count.
		st_next.tx_busy_flag = tx_data_ph || (rate_106 && (tx_start_ph || tx_parity_ph)); // [RL13] [RL14]
		st_next.rx_busy_flag = !rx_start_ph && (rx_data_ph || (rate_106 && rx_parity_ph)); // [RL12] [RL14]

		// Probe bus group by subaddress; D1 and unlisted lines stay undriven.
		st_next.bus_d  = 6'h00;
		st_next.bus_oe = 6'h00;
		unique case (st_reg.test_select_two[sta_pkg::SUBADDR_MSB:0]) // [RL5]
			sta_pkg::BUS_RECEIVER: begin
				st_next.bus_d  = {rx_data_bit, rx_coll, rx_valid, rx_stop, receiver_clear, 1'b0}; // [RL6]
				st_next.bus_oe = 6'h3E;
			end
			sta_pkg::BUS_OSC: begin
				st_next.bus_d  = {osc_stable, st_reg.osc_div_eight, 2'b00, osc_raw_clock, 1'b0}; // [RL7]
				st_next.bus_oe = 6'h32;
			end
			default: st_next.bus_oe = 6'h00;
		endcase

		// Probe pins follow the selector decode one cycle later.
		st_next.p_out = src_out; // [RL8]
		st_next.p_oe  = src_oe;
		st_next.p_dac = src_dac;
		st_next.p_den = src_den;

		// Soft reset returns every register and the sequencer to reset values.
		if (cmd_wr && cmd == sta_pkg::CMD_SOFT_RST) begin
			st_next.self_test_control     = sta_pkg::RST_BYTE;
			st_next.probe_bit_line_select = 3'h0;
			st_next.test_select_two       = sta_pkg::RST_BYTE;
			st_next.probe_route           = sta_pkg::RST_BYTE;
			st_next.test_dac_one          = sta_pkg::RST_DAC;
			st_next.test_dac_two          = sta_pkg::RST_DAC;
			st_next.st                    = sta_pkg::ST_IDLE;
			st_next.idx                   = 7'h00;
			st_next.done                  = 1'b0;
		end
	end

	// State register.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// Signature table with registered read.
	sta_sig_rom #(
		.SILICON_V2 (SILICON_V2)
	) u_rom (
		.clk   (clk),
		.rst_b (rst_b),
		.addr  (st_reg.idx[5:0]),
		.q     (rom_q)
	);

	// Pattern source; the framer adds framing bits while prbs_active is high.
	sta_prbs u_prbs (
		.clk     (clk),
		.rst_b   (rst_b),
		.start   (prbs_start),
		.stop    (prbs_stop),
		.mode    (st_reg.test_select_two[sta_pkg::PRBS_MSB:sta_pkg::PRBS_LSB]),
		.bit_en  (tx_bit_en),
		.bit_q   (prbs_bit),
		.valid_q (prbs_valid),
		.run_q   (prbs_active),
		.mode_q  (prbs_mode)
	);

	// Outputs come straight from the state register.
	assign wb_dat_o      = st_reg.rdat;
	assign wb_ack_o      = st_reg.ack;
	assign fifo_wr_en    = st_reg.fifo_we;
	assign fifo_wr_data  = st_reg.fifo_wd;
	assign probe_bus_d   = st_reg.bus_d;
	assign probe_bus_oe  = st_reg.bus_oe;
	assign probe_pin_one = st_reg.p_out[0];
	assign probe_one_oe  = st_reg.p_oe[0];
	assign probe_one_dac = st_reg.p_dac[5:0];
	assign probe_one_den = st_reg.p_den[0];
	assign probe_pin_two = st_reg.p_out[1];
	assign probe_two_oe  = st_reg.p_oe[1];
	assign probe_two_dac = st_reg.p_dac[11:6];
	assign probe_two_den = st_reg.p_den[1];
endmodule
`default_nettype wire

/* sta_sva.sv */
// Port checks for the self test and probe routing block.
`timescale 1ns/1ps
`default_nettype none
module sta_chk (
	input wire logic       clk,          // Clock.
	input wire logic       rst_b,        // Reset, active low.
	input wire logic       wb_cyc_i,     // Cycle.
	input wire logic       wb_stb_i,     // Strobe.
	input wire logic       wb_ack_o,     // Acknowledge.
	input wire logic       tx_bit_en,    // Bit pace.
	input wire logic       rx_data_bit,  // Received stream.
	input wire logic       osc_stable,   // Stable oscillator.
	input wire logic       fifo_wr_en,   // Push.
	input wire logic [7:0] fifo_wr_data, // Pushed byte.
	input wire logic       prbs_valid,   // Pattern bit pulse.
	input wire logic       prbs_active,  // Pattern running.
	input wire logic [1:0] prbs_mode,    // Pattern kind.
	input wire logic [5:0] probe_bus_d,  // Bus levels.
	input wire logic [5:0] probe_bus_oe  // Bus enables.
);
	logic [6:0] push_cnt; // Length of the running push burst.
	// A burst that is too short or too long is seen only at its end, so it is counted here.
	always_ff @(posedge clk or negedge rst_b)
		if (!rst_b)
			push_cnt <= 7'h00;
		else
			push_cnt <= fifo_wr_en ? push_cnt + 7'h01 : 7'h00;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not acknowledged");
	chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
	chk_burst_len: assert property ($fell(fifo_wr_en) |-> push_cnt == 7'h40) else $error("bad burst");
	chk_first_byte: assert property ($rose(fifo_wr_en) |-> fifo_wr_data == 8'h00) else $error("byte 0");
	chk_rx_group: assert property (probe_bus_oe == 6'h3E |-> probe_bus_d[5] == $past(rx_data_bit))
		else $error("stream not on D6");
	chk_osc_group: assert property (probe_bus_oe == 6'h32 |-> probe_bus_d[5] == $past(osc_stable))
		else $error("oscillator not on D6");
	chk_bus_groups: assert property (probe_bus_oe inside {6'h00, 6'h3E, 6'h32}) else $error("bus oe");
	chk_prbs_pace: assert property (prbs_active && tx_bit_en |=> prbs_valid) else $error("no bit");
	chk_prbs_kind: assert property (prbs_active |-> prbs_mode inside {2'h1, 2'h2}) else $error("mode");
endmodule
bind sta_top sta_chk sta_chk_i (.*);
`default_nettype wire

/* sta_far_model.sv */
// Far side model: receiver, oscillator and framer bit pacing.
`timescale 1ns/1ps
`default_nettype none
module sta_far_model (
	input  wire logic clk,            // Clock.
	input  wire logic rst_b,          // Reset, active low.
	input  wire logic bit_go,         // Framer pacing wanted.
	output logic      rx_data_bit,    // Received stream.
	output logic      rx_coll,        // Collision.
	output logic      rx_valid,       // Valid strobe.
	output logic      rx_stop,        // Stop seen.
	output logic      receiver_clear, // Receiver reset.
	output logic      osc_stable,     // Stable oscillator.
	output logic      osc_raw_clock,  // Raw oscillator.
	output logic      subcarrier_det, // Subcarrier.
	output logic      tx_bit_en       // Bit pace pulse.
);
	logic [5:0] cnt; // Free running phase.
	// The stream bit is slow so that it holds steady across the routing lag.
	always_ff @(posedge clk or negedge rst_b)
		if (!rst_b)
			cnt <= 6'h00;
		else
			cnt <= cnt + 6'h01;
	// Within the receiver bus group every level changes at its own rate, so a swapped line shows up.
	assign {rx_data_bit, rx_coll, rx_valid, rx_stop, receiver_clear} = {cnt[4], cnt[1], cnt[0], cnt[2], cnt[3]};
	assign {osc_stable, osc_raw_clock, subcarrier_det} = {cnt[3], cnt[0], cnt[5]};
	assign tx_bit_en = bit_go && cnt[1:0] == 2'h0;
endmodule
`default_nettype wire

/* tb.sv */
// Self-checking bench for the self test and probe routing block.
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk = 1'b0, rst_b = 1'b0, req = 1'b0, we = 1'b0, bit_go = 1'b0;
	logic rate_106 = 0, tx_start_ph = 0, tx_data_ph = 0, tx_parity_ph = 0, rx_start_ph = 0, rx_data_ph = 0;
	logic rx_parity_ph = 0, wb_ack_o, fifo_wr_en, prbs_valid, prbs_active, probe_pin_one, probe_one_oe;
	logic probe_one_den, probe_pin_two, probe_two_oe, probe_two_den, rx_data_bit, rx_coll, rx_valid, rx_stop;
	logic receiver_clear, osc_stable, osc_raw_clock, subcarrier_det, tx_bit_en;
	logic [7:0] adr = 8'h00, rd, fifo_wr_data, push_q[$];
	logic [31:0] wdat = 32'h0, wb_dat_o;
	logic [5:0] probe_bus_d, probe_bus_oe, probe_one_dac, probe_two_dac;
	logic [1:0] prbs_mode, rx_hist = 2'h0;
	int err_total = 0, num_checks = 0;
	wire logic [8:0] pin1 = {probe_one_oe, probe_one_den, probe_one_oe & probe_pin_one, probe_one_den ? probe_one_dac : 6'h00};
	wire logic [8:0] pin2 = {probe_two_oe, probe_two_den, probe_two_oe & probe_pin_two, probe_two_den ? probe_two_dac : 6'h00};
	sta_top sta_top_i (.*, .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
		.wb_dat_i(wdat), .correlator_out(6'h15), .threshold_level(6'h2A), .adc_i(6'h0C), .adc_q(6'h33), .prbs_bit());
	sta_far_model sta_far_model_i (.*);
	always #20 clk = ~clk;
	// Stream history and pushed bytes, sampled like a flop would.
	always @(posedge clk) begin
		rx_hist <= {rx_hist[0], rx_data_bit};
		if (fifo_wr_en === 1'b1)
			push_q.push_back(fifo_wr_data);
	end
	task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] s);
		num_checks++;
		if (s !== e) begin
			err_total++;
			$display("FAIL %s expected %h seen %h", n, e, s);
		end
	endtask
	// Classic cycle: the request stands until ack is sampled high at a rising edge.
	task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		req <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= {24'h000000, d};
		do @(posedge clk); while (wb_ack_o !== 1'b1);
		rd = wb_dat_o[7:0];
		req <= 1'b0;
	endtask
	// Expected pin {oe, den, level, code} per source code.
	function automatic logic [8:0] expv(input logic [3:0] c, input logic [5:0] dac);
		case (c)
			4'h1: return {3'b010, dac};
			4'h2: return {3'b010, 6'h15};
			4'h4: return {3'b010, 6'h2A};
			4'h5: return {3'b010, 6'h0C};
			4'h6: return {3'b010, 6'h33};
			4'hA: return 9'h140;
			4'hB: return 9'h100;
			default: return 9'h000;
		endcase
	endfunction
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Watchdog well beyond the test length.
	initial begin
		repeat (10000) @(posedge clk);
		err_total++;
		wrap_up();
	end
	// Main sequence.
	initial begin : main
		logic [6:0] pats [4] = '{7'b1100100, 7'b0001001, 7'b1001001, 7'b0010010};
		logic [1:0] flg [4] = '{2'b10, 2'b00, 2'b11, 2'b11};
		logic [7:0] subs [3] = '{8'h0D, 8'h01, 8'h07};
		logic [5:0] oes [3] = '{6'h32, 6'h00, 6'h3E};
		logic [1:0] pm [2] = '{sta_pkg::PRBS_9, sta_pkg::PRBS_15};
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		wb(1'b0, sta_pkg::OFS_SELF_TEST, 8'h00);
		cmp("self test reset", 16'h0000, {8'h00, rd});
		wb(1'b1, 8'h20, 8'h5A);
		wb(1'b0, 8'h20, 8'h00);
		cmp("unmapped read", 16'h0000, {8'h00, rd});
		wb(1'b1, sta_pkg::OFS_DAC_ONE, 8'h3F);
		wb(1'b1, sta_pkg::OFS_DAC_TWO, 8'h00);
		wb(1'b0, sta_pkg::OFS_DAC_ONE, 8'h00);
		cmp("dac one", 16'h003F, {8'h00, rd});
		for (int c = 0; c < 12; c++) begin
			wb(1'b1, sta_pkg::OFS_PROBE_ROUT, {4'(c), 4'(11 - c)});
			repeat (3) @(negedge clk);
			cmp("pin one", {7'h00, expv(4'(c), 6'h3F)}, {7'h00, pin1});
			cmp("pin two", {7'h00, expv(4'(11 - c), 6'h00)}, {7'h00, pin2});
		end
		wb(1'b1, sta_pkg::OFS_PROBE_ROUT, 8'hCD);
		foreach (pats[i]) begin
			@(posedge clk);
			{rate_106, tx_start_ph, tx_data_ph, tx_parity_ph, rx_start_ph, rx_data_ph, rx_parity_ph} <= pats[i];
			repeat (3) @(negedge clk);
			cmp("busy flags", {14'h0, flg[i]}, {14'h0, pin1[6], pin2[6]});
		end
		wb(1'b1, sta_pkg::OFS_TEST_SEL1, 8'h06);
		wb(1'b1, sta_pkg::OFS_PROBE_ROUT, 8'hFF);
		foreach (subs[i]) begin
			wb(1'b1, sta_pkg::OFS_TEST_SEL2, subs[i]);
			repeat (3) @(negedge clk);
			cmp("bus enables", {10'h0, oes[i]}, {10'h0, probe_bus_oe});
		end
		repeat (20) begin
			@(negedge clk);
			cmp("bus bit", {14'h0, 1'b1, rx_hist[1]}, {14'h0, probe_one_oe, probe_pin_one});
		end
		wb(1'b1, sta_pkg::OFS_COMMAND, {4'h0, sta_pkg::CMD_SOFT_RST});
		wb(1'b1, sta_pkg::OFS_COMMAND, {4'h0, sta_pkg::CMD_CHECKSUM});
		repeat (80) @(posedge clk);
		cmp("pushes while off", 16'h0000, 16'(push_q.size()));
		wb(1'b1, sta_pkg::OFS_SELF_TEST, sta_pkg::SELF_TEST_ON);
		wb(1'b1, sta_pkg::OFS_COMMAND, {4'h0, sta_pkg::CMD_CHECKSUM});
		repeat (80) @(posedge clk);
		cmp("signature length", 16'h0040, 16'(push_q.size()));
		cmp("signature byte 1", 16'h00EB, {8'h00, push_q[1]});
		cmp("signature byte 63", 16'h002F, {8'h00, push_q[63]});
		foreach (pm[i]) begin
			wb(1'b1, sta_pkg::OFS_TEST_SEL2, {1'b0, pm[i], 5'h00});
			wb(1'b1, sta_pkg::OFS_COMMAND, {4'h0, sta_pkg::CMD_TRANSMIT});
			bit_go <= 1'b1;
			repeat (20) @(negedge clk);
			cmp("pattern run", {13'h0, 1'b1, pm[i]}, {13'h0, prbs_active, prbs_mode});
			@(posedge clk);
			bit_go <= 1'b0;
			wb(1'b1, sta_pkg::OFS_COMMAND, {4'h0, sta_pkg::CMD_IDLE});
			repeat (3) @(negedge clk);
			cmp("pattern stop", 16'h0000, {15'h0, prbs_active});
		end
		$display("test sequence done");
		wrap_up();
	end
endmodule
`default_nettype wire
